// *** src/cpu_reg_pkg.sv ***
// constants and types for the programmer register model
// Function
// RULE1: eight data registers work on byte, word and long operands
// RULE2: data register results update the status word condition flags
// RULE3: address and user stack targets take word or long, flags kept
// RULE4: address registers and user stack pointer serve as stack or base
// RULE5: any data or general address register may be the index
// RULE6: status high byte and privileged stack written in supervisor only
// RULE7: status word holds a three-bit interrupt mask and five flags
// RULE8: status word holds a trace flag and a supervisor flag
// RULE9: memory side presents a 32-bit address and 16-bit data
// RULE10: general registers and program counter are 32 bits wide
// RULE11: operand types are bit, packed decimal, byte, word and long
// RULE12: user-mode writes to the protected byte or stack are dropped
package cpu_reg_pkg;

	localparam logic [7:0] OFS_COMMAND = 8'h00;
	localparam logic [7:0] OFS_OPERAND = 8'h04;
	localparam logic [7:0] OFS_STATUS_WORD = 8'h08;
	localparam logic [7:0] OFS_PC = 8'h0C;
	localparam logic [7:0] OFS_EXEC = 8'h10;
	localparam logic [7:0] OFS_EA = 8'h14;
	localparam logic [7:0] OFS_DATA_BASE = 8'h40;
	localparam logic [7:0] OFS_PRIV_STACK = 8'h80;

	localparam int NUM_REGS = 17;
	localparam logic [4:0] IDX_ADDR0 = 5'h08;
	localparam logic [4:0] IDX_USER_STACK = 5'h0F;
	localparam logic [4:0] IDX_PRIV_STACK = 5'h10;

	localparam int SW_C = 0;
	localparam int SW_V = 1;
	localparam int SW_Z = 2;
	localparam int SW_N = 3;
	localparam int SW_X = 4;
	localparam int SW_MASK_LO = 8;
	localparam int SW_SUPER = 13;
	localparam int SW_TRACE = 15;
	localparam logic [15:0] SW_RESET = 16'h2700;
	localparam logic [7:0] SW_LO_WRITABLE = 8'h1F;
	localparam logic [7:0] SW_HI_WRITABLE = 8'hA7;

	localparam int CMD_OP_LO = 0;
	localparam int CMD_SIZE_LO = 4;
	localparam int CMD_DEST_ADDR = 6;
	localparam int CMD_DEST_LO = 7;
	localparam int CMD_IDX_ADDR = 10;
	localparam int CMD_IDX_LO = 11;
	localparam int CMD_IDX_LONG = 14;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [1:0] SIZE_RESERVED = 2'h3;

	localparam int EXEC_ERR = 1;
	localparam logic [31:0] PC_RESET = 32'h00000000;
	localparam logic [31:0] PC_STEP = 32'h00000002;
	localparam logic [31:0] STORE_STEP = 32'h00000002;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [3:0] {
		OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR,
		OP_BSET, OP_ABCD, OP_LEA, OP_STORE
	} op_t;

	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_STORE_LO} state_t;

	// field 7 of an address selector is the active stack pointer
	function automatic logic [4:0] reg_index(input logic is_addr,
		input logic [2:0] n, input logic sup_mode);
		if (!is_addr)
			reg_index = {2'b00, n};
		else if (n == 3'h7)
			reg_index = sup_mode ? IDX_PRIV_STACK : IDX_USER_STACK;
		else
			reg_index = IDX_ADDR0 | {2'b00, n};
	endfunction

endpackage

// *** src/cpu_gpr_file.sv ***
// general register storage with two registered read ports
`timescale 1ns/1ps
module cpu_gpr_file
	import cpu_reg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic wr_en,
	input wire logic [4:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [4:0] rd_a_idx,
	output logic [31:0] rd_a_data,
	input wire logic [4:0] rd_b_idx,
	output logic [31:0] rd_b_data
);

	logic [31:0] mem [0:NUM_REGS-1];

	always_ff @(posedge ref_clk) begin
		if (wr_en && (wr_idx <= IDX_PRIV_STACK))
			mem[wr_idx] <= wr_data;
		// holes read as zero rather than unknown
		rd_a_data <= (rd_a_idx <= IDX_PRIV_STACK) ? mem[rd_a_idx]
			: 32'h00000000;
		rd_b_data <= (rd_b_idx <= IDX_PRIV_STACK) ? mem[rd_b_idx]
			: 32'h00000000;
	end

endmodule

// *** src/cpu_programmer_register_model.sv ***
// programmer register model with an AHB-Lite register slave
`timescale 1ns/1ps
module cpu_programmer_register_model
	import cpu_reg_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic mem_wr,
	output logic supervisor_mode,
	output logic trace_mode,
	output logic [2:0] irq_mask_level
);

	logic rst_q1;
	logic rst_sync_b;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_q1 <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_sync_b <= rst_q1;
		end
	end

	function automatic logic [31:0] align(input logic [31:0] v,
		input size_t sz);
		case (sz)
		SZ_BYTE: align = {v[7:0], 24'h000000};
		SZ_WORD: align = {v[15:0], 16'h0000};
		default: align = v;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] d,
		input logic [31:0] r_al, input size_t sz);
		case (sz)
		SZ_BYTE: merge = {d[31:8], r_al[31:24]};
		SZ_WORD: merge = {d[31:16], r_al[31:16]};
		default: merge = r_al;
		endcase
	endfunction

	function automatic logic [4:0] bcd_digit(input logic [3:0] a,
		input logic [3:0] b, input logic cin);
		logic [4:0] s;
		s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
		bcd_digit = (s > 5'h09) ? 5'(s + 5'h06) : s;
	endfunction

	state_t state;
	logic [15:0] command;
	logic [31:0] operand;
	logic [15:0] status_word;
	logic [31:0] pc;
	logic [31:0] ea_result;
	logic exec_err;
	logic [15:0] store_lo;

	logic dphase;
	logic settled;
	logic [7:0] a_ofs;
	logic a_write;
	logic a_word;

	logic [31:0] rd_a_data;
	logic [31:0] rd_b_data;

	wire busy = (state != ST_IDLE);
	wire s_bit = status_word[SW_SUPER];
	wire accept = hsel && htrans[1] && hready;
	wire complete = dphase && settled && !busy;
	wire bus_wr = complete && a_write && a_word;
	wire a_gpr_hit = (a_ofs >= OFS_DATA_BASE) && (a_ofs <= OFS_PRIV_STACK)
		&& (a_ofs[1:0] == 2'b00);
	wire [7:0] a_rel = a_ofs - OFS_DATA_BASE;
	wire [4:0] a_gpr_idx = a_rel[6:2];

	wire cmd_wr = bus_wr && (a_ofs == OFS_COMMAND);
	wire opnd_wr = bus_wr && (a_ofs == OFS_OPERAND);
	wire sw_wr = bus_wr && (a_ofs == OFS_STATUS_WORD);
	wire pc_wr = bus_wr && (a_ofs == OFS_PC);
	wire err_clr = bus_wr && (a_ofs == OFS_EXEC) && hwdata[EXEC_ERR];
	// RULE6 privileged stack guard
	wire priv_locked = (a_gpr_idx == IDX_PRIV_STACK) && !s_bit;
	wire bus_gpr_we = bus_wr && a_gpr_hit && !priv_locked;

	op_t cmd_op;
	size_t cmd_size;
	assign cmd_op = op_t'(command[CMD_OP_LO +: 4]);
	assign cmd_size = size_t'(command[CMD_SIZE_LO +: 2]);
	wire size_ok = command[CMD_SIZE_LO +: 2] != SIZE_RESERVED;
	wire dest_addr = command[CMD_DEST_ADDR];
	// RULE4 stack pointer select
	wire [4:0] dest_idx = reg_index(dest_addr,
		command[CMD_DEST_LO +: 3], s_bit);
	// RULE5 index from either bank
	wire [4:0] idx_idx = reg_index(command[CMD_IDX_ADDR],
		command[CMD_IDX_LO +: 3], s_bit);
	wire [4:0] port_a_idx = busy ? dest_idx : a_gpr_idx;

	// RULE1 sized data arithmetic
	wire [31:0] dst_al = align(rd_a_data, cmd_size);
	wire [31:0] src_al = align(operand, cmd_size);
	wire [32:0] add_al = {1'b0, dst_al} + {1'b0, src_al};
	wire [32:0] sub_al = {1'b0, dst_al} - {1'b0, src_al};

	// RULE3 address targets use sign-extended words on all 32 bits
	wire [31:0] addr_src = (cmd_size == SZ_WORD)
		? {{16{operand[15]}}, operand[15:0]} : operand;
	wire [31:0] addr_res = (cmd_op == OP_ADD) ? rd_a_data + addr_src
		: (cmd_op == OP_SUB) ? rd_a_data - addr_src : addr_src;

	// RULE11 bit and packed decimal operands
	wire [4:0] bit_pos = operand[4:0];
	wire bit_was = rd_a_data[bit_pos];
	wire [31:0] bit_set = rd_a_data | (32'h00000001 << bit_pos);
	wire [4:0] bcd_lo = bcd_digit(rd_a_data[3:0], operand[3:0],
		status_word[SW_X]);
	wire [4:0] bcd_hi = bcd_digit(rd_a_data[7:4], operand[7:4], bcd_lo[4]);
	wire [7:0] bcd_byte = {bcd_hi[3:0], bcd_lo[3:0]};

	// RULE5 indexed address with 8-bit displacement
	wire [31:0] idx_val = command[CMD_IDX_LONG] ? rd_b_data
		: {{16{rd_b_data[15]}}, rd_b_data[15:0]};
	wire [31:0] disp = {{24{operand[7]}}, operand[7:0]};
	wire [31:0] ea_sum = rd_a_data + idx_val + disp;

	logic [31:0] res_al;
	logic carry;
	logic ovf;

	always_comb begin
		res_al = src_al;
		carry = 1'b0;
		ovf = 1'b0;
		case (cmd_op)
		OP_ADD: begin
			res_al = add_al[31:0];
			carry = add_al[32];
			ovf = (dst_al[31] == src_al[31]) && (add_al[31] != dst_al[31]);
		end
		OP_SUB: begin
			res_al = sub_al[31:0];
			carry = sub_al[32];
			ovf = (dst_al[31] != src_al[31]) && (sub_al[31] != dst_al[31]);
		end
		OP_AND: res_al = dst_al & src_al;
		OP_OR: res_al = dst_al | src_al;
		default: res_al = src_al;
		endcase
	end

	logic legal;
	logic gpr_we_exec;
	logic flags_we;
	logic [31:0] exec_value;
	logic [4:0] flags_new;

	always_comb begin
		legal = 1'b0;
		gpr_we_exec = 1'b0;
		flags_we = 1'b0;
		exec_value = rd_a_data;
		flags_new = status_word[4:0];
		case (cmd_op)
		OP_MOVE, OP_ADD, OP_SUB, OP_AND, OP_OR: begin
			if (dest_addr) begin
				// RULE3 no byte size, no flag change
				legal = size_ok && (cmd_size != SZ_BYTE)
					&& (cmd_op != OP_AND) && (cmd_op != OP_OR);
				exec_value = addr_res;
			end else begin
				legal = size_ok;
				exec_value = merge(rd_a_data, res_al, cmd_size);
				// RULE2 flags from the sized result
				flags_we = legal;
				flags_new[SW_N] = res_al[31];
				flags_new[SW_Z] = (res_al == 32'h00000000);
				flags_new[SW_V] = ovf;
				flags_new[SW_C] = carry;
				if ((cmd_op == OP_ADD) || (cmd_op == OP_SUB))
					flags_new[SW_X] = carry;
			end
			gpr_we_exec = legal;
		end
		OP_BSET: begin
			legal = !dest_addr;
			exec_value = bit_set;
			flags_new[SW_Z] = !bit_was;
			flags_we = legal;
			gpr_we_exec = legal;
		end
		OP_ABCD: begin
			legal = !dest_addr;
			exec_value = {rd_a_data[31:8], bcd_byte};
			flags_new[SW_C] = bcd_hi[4];
			flags_new[SW_X] = bcd_hi[4];
			// zero only ever cleared, so chained digits test whole value
			if (bcd_byte != 8'h00)
				flags_new[SW_Z] = 1'b0;
			flags_we = legal;
			gpr_we_exec = legal;
		end
		OP_LEA: legal = dest_addr;
		OP_STORE: legal = size_ok;
		default: legal = 1'b0;
		endcase
	end

	wire in_exec = (state == ST_EXEC);
	wire exec_we = in_exec && gpr_we_exec;
	wire gpr_we = exec_we || bus_gpr_we;
	wire [4:0] gpr_wr_idx = exec_we ? dest_idx : a_gpr_idx;
	wire [31:0] gpr_wr_data = exec_we ? exec_value : hwdata;

	// RULE10 all general registers 32 bits
	cpu_gpr_file gpr (
		.ref_clk(ref_clk),
		.wr_en(gpr_we),
		.wr_idx(gpr_wr_idx),
		.wr_data(gpr_wr_data),
		.rd_a_idx(port_a_idx),
		.rd_a_data(rd_a_data),
		.rd_b_idx(idx_idx),
		.rd_b_data(rd_b_data)
	);

	wire [31:0] rd_value = a_gpr_hit ? rd_a_data
		: (a_ofs == OFS_COMMAND) ? {16'h0000, command}
		: (a_ofs == OFS_OPERAND) ? operand
		: (a_ofs == OFS_STATUS_WORD) ? {16'h0000, status_word}
		: (a_ofs == OFS_PC) ? pc
		: (a_ofs == OFS_EXEC) ? {30'h0, exec_err, 1'b0}
		: (a_ofs == OFS_EA) ? ea_result : 32'h00000000;

	// data phase waits for the register file read to settle
	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			dphase <= 1'b0;
			settled <= 1'b0;
			a_ofs <= 8'h00;
			a_write <= 1'b0;
			a_word <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end else if (accept) begin
			dphase <= 1'b1;
			settled <= 1'b0;
			a_ofs <= haddr[7:0];
			a_write <= hwrite;
			a_word <= (hsize == HSIZE_WORD);
			hreadyout <= 1'b0;
		end else if (complete) begin
			dphase <= 1'b0;
			settled <= 1'b0;
			hreadyout <= 1'b1;
			hrdata <= a_write ? 32'h00000000 : rd_value;
		end else begin
			settled <= dphase && !busy;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			command <= CMD_RESET;
			operand <= 32'h00000000;
		end else begin
			if (cmd_wr)
				command <= hwdata[15:0];
			if (opnd_wr)
				operand <= hwdata;
		end
	end

	// RULE7 RULE8 mask, trace and supervisor live in the high byte
	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			status_word <= SW_RESET;
		end else if (in_exec && flags_we) begin
			status_word[4:0] <= flags_new;
		end else if (sw_wr) begin
			status_word[7:0] <= hwdata[7:0] & SW_LO_WRITABLE;
			// RULE12 user write leaves high byte intact
			if (s_bit)
				status_word[15:8] <= hwdata[15:8] & SW_HI_WRITABLE;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pc <= PC_RESET;
			ea_result <= 32'h00000000;
			exec_err <= 1'b0;
		end else begin
			// RULE10 program counter steps per command
			if (in_exec)
				pc <= pc + PC_STEP;
			else if (pc_wr)
				pc <= hwdata;
			if (in_exec && legal && (cmd_op == OP_LEA))
				ea_result <= ea_sum;
			// refusal wins over a clear in the same cycle
			if (in_exec && !legal)
				exec_err <= 1'b1;
			else if (err_clr)
				exec_err <= 1'b0;
		end
	end

	// RULE9 long stores leave as two 16-bit beats, high word first
	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state <= ST_IDLE;
			mem_addr <= 32'h00000000;
			mem_wdata <= 16'h0000;
			mem_wr <= 1'b0;
			store_lo <= 16'h0000;
		end else begin
			mem_wr <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (cmd_wr)
					state <= ST_FETCH;
			end
			ST_FETCH: state <= ST_EXEC;
			ST_EXEC: begin
				state <= ST_IDLE;
				if (legal && (cmd_op == OP_STORE)) begin
					mem_addr <= operand;
					mem_wr <= 1'b1;
					store_lo <= rd_a_data[15:0];
					if (cmd_size == SZ_LONG) begin
						mem_wdata <= rd_a_data[31:16];
						state <= ST_STORE_LO;
					end else if (cmd_size == SZ_BYTE) begin
						mem_wdata <= {8'h00, rd_a_data[7:0]};
					end else begin
						mem_wdata <= rd_a_data[15:0];
					end
				end
			end
			ST_STORE_LO: begin
				mem_addr <= mem_addr + STORE_STEP;
				mem_wdata <= store_lo;
				mem_wr <= 1'b1;
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			supervisor_mode <= 1'b1;
			trace_mode <= 1'b0;
			irq_mask_level <= 3'h7;
		end else begin
			supervisor_mode <= status_word[SW_SUPER];
			trace_mode <= status_word[SW_TRACE];
			irq_mask_level <= status_word[SW_MASK_LO +: 3];
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_sync_b);

	property p_priv_locked;
		(bus_wr && a_gpr_hit && (a_gpr_idx == IDX_PRIV_STACK) && !s_bit)
			|-> !gpr_we;
	endproperty
	a_priv_locked: assert property (p_priv_locked) // RULE12
		else $error("user write reached privileged stack pointer");

	property p_sw_high_kept;
		(sw_wr && !s_bit) |=> status_word[15:8] == $past(status_word[15:8]);
	endproperty
	a_sw_high_kept: assert property (p_sw_high_kept) // RULE6
		else $error("user write changed status high byte");

	property p_addr_flags_kept;
		(in_exec && dest_addr)
			|=> status_word[4:0] == $past(status_word[4:0]);
	endproperty
	a_addr_flags_kept: assert property (p_addr_flags_kept) // RULE3
		else $error("address target changed condition flags");

	property p_addr_byte_refused;
		(in_exec && dest_addr && (cmd_op == OP_MOVE) && (cmd_size == SZ_BYTE))
			|-> !gpr_we ##1 exec_err;
	endproperty
	a_addr_byte_refused: assert property (p_addr_byte_refused) // RULE3
		else $error("byte move to address register not refused");

	property p_move_zero_flag;
		(in_exec && !dest_addr && (cmd_op == OP_MOVE) && size_ok)
			|=> status_word[SW_Z] == ($past(src_al) == 32'h00000000);
	endproperty
	a_move_zero_flag: assert property (p_move_zero_flag) // RULE2
		else $error("zero flag wrong after data move");

	property p_byte_merge;
		(in_exec && !dest_addr && (cmd_op == OP_MOVE) && (cmd_size == SZ_BYTE))
			|-> gpr_we && (gpr_wr_data[31:8] == rd_a_data[31:8]);
	endproperty
	a_byte_merge: assert property (p_byte_merge) // RULE1
		else $error("byte move disturbed upper bits");

	property p_user_stack_select;
		(exec_we && dest_addr && (command[CMD_DEST_LO +: 3] == 3'h7) && !s_bit)
			|-> gpr_wr_idx == IDX_USER_STACK;
	endproperty
	a_user_stack_select: assert property (p_user_stack_select) // RULE4
		else $error("user stack pointer not selected in user mode");

	property p_lea_sum;
		(in_exec && legal && (cmd_op == OP_LEA))
			|=> ea_result == $past(rd_a_data) + $past(idx_val) + $past(disp);
	endproperty
	a_lea_sum: assert property (p_lea_sum) // RULE5
		else $error("indexed address sum wrong");

	property p_bset_zero;
		(in_exec && legal && (cmd_op == OP_BSET))
			|=> status_word[SW_Z] == !$past(bit_was);
	endproperty
	a_bset_zero: assert property (p_bset_zero) // RULE11
		else $error("bit operation zero flag wrong");

	sequence s_store_long;
		in_exec && legal && (cmd_op == OP_STORE) && (cmd_size == SZ_LONG);
	endsequence
	sequence s_two_beats;
		mem_wr ##1 (mem_wr && (mem_addr == $past(mem_addr) + STORE_STEP));
	endsequence
	property p_store_long;
		s_store_long |=> s_two_beats;
	endproperty
	a_store_long: assert property (p_store_long) // RULE9
		else $error("long store not split into two beats");

	property p_pc_step;
		in_exec |=> pc == $past(pc) + PC_STEP;
	endproperty
	a_pc_step: assert property (p_pc_step) // RULE10
		else $error("program counter did not step");

	property p_mode_out;
		1'b1 |=> supervisor_mode == $past(status_word[SW_SUPER]);
	endproperty
	a_mode_out: assert property (p_mode_out) // RULE8
		else $error("supervisor output does not follow status word");

	property p_bus_answer;
		accept |=> !hreadyout ##[1:8] hreadyout;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus transfer not answered in time");

endmodule

// *** test/test_cpu_programmer_register_model.sv ***
// self-checking bench for the programmer register model
`timescale 1ns/1ps
module test_cpu_programmer_register_model import cpu_reg_pkg::*;;
	typedef struct {
		op_t op;
		size_t sz;
		logic [31:0] init;
		logic [31:0] opnd;
		logic [31:0] res;
		logic [31:0] sw;
	} case_t;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] mem_addr;
	logic [15:0] mem_wdata;
	logic mem_wr;
	logic supervisor_mode;
	logic trace_mode;
	logic [2:0] irq_mask_level;
	logic [47:0] beats[$];
	case_t tbl[8];
	int fails = 0;
	int check_count = 0;
	int cmds = 0;
	localparam logic [7:0] D2 = 8'h48;
	localparam logic [7:0] A2 = 8'h68;
	localparam logic [7:0] A3 = 8'h6C;
	localparam logic [7:0] USER_STACK = 8'h7C;

	cpu_programmer_register_model dut (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.mem_addr(mem_addr),
		.mem_wdata(mem_wdata),
		.mem_wr(mem_wr),
		.supervisor_mode(supervisor_mode),
		.trace_mode(trace_mode),
		.irq_mask_level(irq_mask_level)
	);

	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end

	// beats are looked at mid-cycle, clear of the launching edge
	always @(negedge ref_clk) begin
		if (mem_wr === 1'b1)
			beats.push_back({mem_addr, mem_wdata});
	end

	task automatic close_out;
		if (fails == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// entered just after a rising edge; returns just after one
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		do begin
			@(negedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		@(posedge ref_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 80);
		q = hrdata;
		if (n >= 80)
			chk("bus wait", 32'(n), 32'h0);
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rc(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, q, exp);
	endtask

	function automatic logic [15:0] mk(op_t op, size_t sz, logic da,
		logic [2:0] dn, logic ia, logic [2:0] xn, logic xl);
		mk = {1'b0, xl, xn, ia, dn, da, sz, op};
	endfunction

	task automatic run(input logic [15:0] cmd, input logic [31:0] opnd);
		wr(OFS_OPERAND, opnd);
		wr(OFS_COMMAND, {16'h0000, cmd});
		cmds++;
	endtask

	initial begin
		#(25 * 5000);
		chk("watchdog", 32'h1, 32'h0);
		close_out();
	end

	initial begin
		tbl[0] = '{OP_MOVE, SZ_BYTE, 32'h11223344, 32'hF0, 32'h112233F0,
			32'h2708};
		tbl[1] = '{OP_ADD, SZ_LONG, 32'hFFFFFFFF, 32'h1, 32'h0, 32'h2715};
		tbl[2] = '{OP_SUB, SZ_WORD, 32'hAAAA0000, 32'h1, 32'hAAAAFFFF,
			32'h2719};
		tbl[3] = '{OP_ADD, SZ_BYTE, 32'h7F, 32'h1, 32'h80, 32'h270A};
		tbl[4] = '{OP_AND, SZ_LONG, 32'hF0F0F0F0, 32'h0F0F0F0F, 32'h0,
			32'h2704};
		tbl[5] = '{OP_OR, SZ_WORD, 32'h12340000, 32'h8001, 32'h12348001,
			32'h2708};
		tbl[6] = '{OP_BSET, SZ_LONG, 32'h0, 32'h5, 32'h20, 32'h2704};
		tbl[7] = '{OP_ABCD, SZ_BYTE, 32'h55, 32'h55, 32'h10, 32'h2711};
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk("super out", 32'(supervisor_mode), 32'h1);
		chk("trace out", 32'(trace_mode), 32'h0);
		chk("mask out", 32'(irq_mask_level), 32'h7);
		rc("status reset", OFS_STATUS_WORD, 32'h2700);
		rc("pc reset", OFS_PC, 32'h0);
		rc("unmapped", 8'h30, 32'h0);
		chk("hresp", 32'(hresp), 32'h0);
		for (int i = 0; i < 8; i++) begin
			wr(OFS_STATUS_WORD, 32'h2700);
			wr(D2, tbl[i].init);
			run(mk(tbl[i].op, tbl[i].sz, 1'b0, 3'h2, 1'b0, 3'h0, 1'b0),
				tbl[i].opnd);
			rc("data result", D2, tbl[i].res);
			rc("data flags", OFS_STATUS_WORD, tbl[i].sw);
		end
		wr(OFS_STATUS_WORD, 32'h271F);
		wr(A2, 32'h1000);
		run(mk(OP_ADD, SZ_WORD, 1'b1, 3'h2, 1'b0, 3'h0, 1'b0), 32'hFFFE);
		rc("addr add", A2, 32'h0FFE);
		rc("addr flags", OFS_STATUS_WORD, 32'h271F);
		run(mk(OP_MOVE, SZ_BYTE, 1'b1, 3'h2, 1'b0, 3'h0, 1'b0), 32'h55);
		rc("byte to addr err", OFS_EXEC, 32'h2);
		rc("addr kept", A2, 32'h0FFE);
		wr(OFS_EXEC, 32'h2);
		rc("err cleared", OFS_EXEC, 32'h0);
		wr(D2, 32'h0000FFF0);
		wr(A3, 32'h100);
		run(mk(OP_LEA, SZ_LONG, 1'b1, 3'h2, 1'b0, 3'h2, 1'b0), 32'h04);
		rc("ea data index", OFS_EA, 32'h0FF2);
		run(mk(OP_LEA, SZ_LONG, 1'b1, 3'h2, 1'b1, 3'h3, 1'b1), 32'hFC);
		rc("ea addr index", OFS_EA, 32'h10FA);
		wr(D2, 32'hCAFEBABE);
		beats.delete();
		run(mk(OP_STORE, SZ_LONG, 1'b0, 3'h2, 1'b0, 3'h0, 1'b0), 32'h2000);
		run(mk(OP_STORE, SZ_BYTE, 1'b0, 3'h2, 1'b0, 3'h0, 1'b0), 32'h3000);
		rc("pc step", OFS_PC, 32'(cmds) * PC_STEP);
		repeat (3) @(posedge ref_clk);
		chk("beat count", 32'(beats.size()), 32'h3);
		if (beats.size() == 3) begin
			chk("beat hi", beats[0][31:0], 32'h2000CAFE);
			chk("beat hi addr", beats[0][47:16], 32'h2000);
			chk("beat lo", beats[1][31:0], 32'h2002BABE);
			chk("beat lo addr", beats[1][47:16], 32'h2002);
			chk("beat byte", beats[2][31:0], 32'h300000BE);
		end
		run(mk(OP_MOVE, SZ_LONG, 1'b1, 3'h7, 1'b0, 3'h0, 1'b0), 32'h5555AAAA);
		rc("priv stack by sel", OFS_PRIV_STACK, 32'h5555AAAA);
		wr(OFS_STATUS_WORD, 32'hFFFF);
		@(negedge ref_clk);
		chk("trace on", 32'(trace_mode), 32'h1);
		@(posedge ref_clk);
		rc("status bits", OFS_STATUS_WORD, 32'hA71F);
		wr(OFS_STATUS_WORD, 32'h001F);
		repeat (2) @(negedge ref_clk);
		chk("user mode", 32'(supervisor_mode), 32'h0);
		chk("mask zero", 32'(irq_mask_level), 32'h0);
		chk("trace off", 32'(trace_mode), 32'h0);
		@(posedge ref_clk);
		wr(OFS_PRIV_STACK, 32'h1234);
		rc("priv stack locked", OFS_PRIV_STACK, 32'h5555AAAA);
		wr(OFS_STATUS_WORD, 32'hA700);
		rc("high byte locked", OFS_STATUS_WORD, 32'h0000);
		run(mk(OP_MOVE, SZ_LONG, 1'b1, 3'h7, 1'b0, 3'h0, 1'b0), 32'h77);
		rc("user stack by sel", USER_STACK, 32'h77);
		rc("priv stack still", OFS_PRIV_STACK, 32'h5555AAAA);
		@(negedge ref_clk);
		chk("still user", 32'(supervisor_mode), 32'h0);
		@(posedge ref_clk);
		hsize <= 3'h0;
		wr(D2, 32'h0);
		hsize <= HSIZE_WORD;
		rc("narrow write dropped", D2, 32'hCAFEBABE);
		beats.delete();
		run(mk(OP_STORE, SZ_WORD, 1'b0, 3'h2, 1'b0, 3'h0, 1'b0), 32'h4000);
		run(mk(OP_MOVE, size_t'(SIZE_RESERVED), 1'b0, 3'h2, 1'b0, 3'h0,
			1'b0), 32'h1);
		rc("reserved size err", OFS_EXEC, 32'h2);
		rc("reserved size kept", D2, 32'hCAFEBABE);
		chk("word beats", 32'(beats.size()), 32'h1);
		if (beats.size() == 1)
			chk("word beat", beats[0][31:0], 32'h4000BABE);
		close_out();
	end
endmodule
